/* src/mid_pkg.sv */
// Constants and carrier types for the instruction decoder core
package mid_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned PHASES_PER_CYCLE = 4;
    localparam logic [1:0] FETCH_PHASE = 2'h1;
    localparam logic [1:0] LAST_PHASE = 2'(PHASES_PER_CYCLE - 1);
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_ACC = 5'h08;
    localparam logic [4:0] REG_PC = 5'h0c;
    localparam logic [4:0] REG_WAKE = 5'h10;
    localparam logic [6:0] FA_TIMER0 = 7'h01;
    localparam logic [6:0] FA_PCLOW = 7'h02;
    localparam logic [6:0] FA_STATUS = 7'h03;
    localparam logic [6:0] FA_PORT = 7'h06;
    localparam logic [13:0] CW_RETURN = 14'h0008;
    localparam logic [13:0] CW_RETINT = 14'h0009;
    localparam logic [13:0] CW_STANDBY = 14'h0063;
    localparam logic [13:0] CW_WDOG_CLEAR = 14'h0064;
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    typedef enum logic [3:0] {
        OP_MOVE_W, OP_CLEAR, OP_SUB_W, OP_DEC, OP_OR_W, OP_AND_W, OP_XOR_W, OP_ADD_W,
        OP_MOVE_F, OP_COMPL, OP_INC, OP_DEC_SKIP, OP_ROT_RIGHT, OP_ROT_LEFT, OP_SWAP,
        OP_INC_SKIP
    } mid_byte_op_t;
    localparam logic [3:0] LIT_OR = 4'h8;
    localparam logic [3:0] LIT_AND = 4'h9;
    localparam logic [3:0] LIT_XOR = 4'ha;
    typedef struct packed {
        logic timeoutFlag;
        logic powerdownFlag;
        logic zero;
        logic digitCarryFlag;
        logic carry;
    } mid_flags_t;
    localparam mid_flags_t FLAGS_RESET = 5'h18;
    typedef struct packed {
        logic [1:0] phase;
        logic run;
        logic prescaleToTimer;
        logic sleeping;
        logic flush;
        logic [13:0] ir;
        logic [12:0] pc;
        logic [7:0] acc;
        mid_flags_t flags;
        logic [2:0] sp;
        logic [7:0] portOut;
        logic [7:0] portMeta;
        logic [7:0] portSync;
        logic ack;
        logic [31:0] rdata;
        logic wdogClear;
        logic prescaleClear;
    } mid_state_t;
    localparam mid_state_t ST_RESET = '{flags: FLAGS_RESET, pc: PC_RESET, default: '0};
endpackage

/* src/mid_core.sv */
// Instruction decode and execution core with Avalon-MM control slave
// Notes on behaviour
// - Decrement-skip writes decremented value to destination, skips next if zero.
// - Increment-skip writes incremented value to destination, skips next if zero.
// - Byte OR of accumulator and file, to destination, touches zero only.
// - Byte XOR of accumulator and file, to destination, touches zero only.
// - Rotates left or right through carry, to destination, touch carry only.
// - Bit group clears, sets, skips on clear or skips on set, by three-bit index.
// - Bit test skips next instruction when the bit is clear, flags untouched.
// - Literal OR into accumulator, zero flag only, one cycle.
// - Literal XOR into accumulator, zero flag only.
// - Literal minus accumulator into accumulator, updates carry, digit carry, zero.
// - Return loading literal into accumulator takes two cycles.
// - Standby word sets timeout, clears powerdown, one cycle.
// - Port reads for read-modify-write use synchronised pin levels, not latch.
// - Writing the timer zero register clears prescaler when assigned to it.
// - Taken skips and program counter changes cost a second, idle cycle.
// - Destination bit zero writes accumulator, one writes the file register.
// - Each instruction cycle spans four clock periods paced by a phase counter.
`timescale 1ns/1ps
`default_nettype none
module mid_core #(
    parameter int STACK_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [12:0] progAddr,
    input wire logic [13:0] progData,
    input wire logic [7:0] portPins,
    output logic [7:0] portOut,
    output logic wdogClear,
    output logic prescaleClear,
    output logic standby
);
    if (STACK_DEPTH < 2 || STACK_DEPTH > 8) begin : g_bad_depth
        $error("STACK_DEPTH must lie between 2 and 8");
    end

    localparam logic [2:0] SP_TOP = 3'(STACK_DEPTH - 1);

    mid_pkg::mid_state_t st_q;
    mid_pkg::mid_state_t st_d;
    logic [7:0] fileMem [0:127];
    logic [12:0] stkMem [0:STACK_DEPTH-1];
    logic [7:0] fval;
    logic [7:0] res;
    logic [9:0] sum;
    logic [7:0] bitMask;
    logic [6:0] fileAddr;
    logic [2:0] spInc;
    logic [2:0] spDec;
    logic memWe;
    logic stkWe;
    logic [12:0] stkWdata;
    logic exec;
    logic wrDest;
    logic toFile;
    logic skipTake;
    logic updZ;
    logic updC;
    logic updDC;

    function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {full[8], lo[4], full[7:0]};
    endfunction

    assign fileAddr = st_q.ir[6:0];
    assign bitMask = 8'h01 << st_q.ir[9:7];
    assign spInc = (st_q.sp == SP_TOP) ? 3'h0 : st_q.sp + 3'h1;
    assign spDec = (st_q.sp == 3'h0) ? SP_TOP : st_q.sp - 3'h1;
    assign exec = st_q.run && st_q.phase == mid_pkg::LAST_PHASE && !st_q.sleeping
                  && !st_q.flush;

    always_comb begin
        case (fileAddr)
            mid_pkg::FA_PORT: fval = st_q.portSync;
            mid_pkg::FA_STATUS: fval = {3'h0, st_q.flags};
            mid_pkg::FA_PCLOW: fval = st_q.pc[7:0];
            default: fval = fileMem[fileAddr];
        endcase
    end

    always_comb begin
        st_d = st_q;
        res = 8'h00;
        sum = 10'h000;
        memWe = 1'b0;
        stkWe = 1'b0;
        stkWdata = 13'h0000;
        wrDest = 1'b0;
        toFile = 1'b0;
        skipTake = 1'b0;
        updZ = 1'b0;
        updC = 1'b0;
        updDC = 1'b0;
        st_d.wdogClear = 1'b0;
        st_d.prescaleClear = 1'b0;
        st_d.portMeta = portPins;
        st_d.portSync = st_q.portMeta;
        st_d.ack = (avs_read | avs_write) & ~st_q.ack;
        if (avs_read && !st_q.ack) begin
            case (avs_address)
                mid_pkg::REG_CTRL: st_d.rdata = {30'h0, st_q.prescaleToTimer, st_q.run};
                mid_pkg::REG_STATUS: st_d.rdata = {26'h0, st_q.sleeping, st_q.flags};
                mid_pkg::REG_ACC: st_d.rdata = {24'h0, st_q.acc};
                mid_pkg::REG_PC: st_d.rdata = {19'h0, st_q.pc};
                default: st_d.rdata = 32'h0;
            endcase
        end
        if (avs_write && st_q.ack) begin
            case (avs_address)
                mid_pkg::REG_CTRL: begin
                    st_d.run = avs_writedata[0];
                    st_d.prescaleToTimer = avs_writedata[1];
                end
                mid_pkg::REG_WAKE: begin
                    if (avs_writedata[0]) st_d.sleeping = 1'b0;
                end
                default: ;
            endcase
        end
        if (st_q.run) st_d.phase = st_q.phase + 2'h1;
        if (st_q.run && st_q.phase == mid_pkg::FETCH_PHASE) st_d.ir = progData;
        if (st_q.run && st_q.phase == mid_pkg::LAST_PHASE && st_q.flush) begin
            st_d.flush = 1'b0;
        end
        if (exec) begin
            st_d.pc = st_q.pc + 13'h0001;
            case (st_q.ir[13:12])
                mid_pkg::GRP_BYTE: begin
                    toFile = st_q.ir[7];
                    wrDest = 1'b1;
                    updZ = 1'b1;
                    case (mid_pkg::mid_byte_op_t'(st_q.ir[11:8]))
                        mid_pkg::OP_MOVE_W: begin
                            updZ = 1'b0;
                            wrDest = st_q.ir[7];
                            res = st_q.acc;
                            case (st_q.ir)
                                mid_pkg::CW_RETURN, mid_pkg::CW_RETINT: begin
                                    st_d.sp = spDec;
                                    st_d.pc = stkMem[spDec];
                                    st_d.flush = 1'b1;
                                end
                                mid_pkg::CW_STANDBY: begin
                                    st_d.sleeping = 1'b1;
                                    st_d.flags.timeoutFlag = 1'b1;
                                    st_d.flags.powerdownFlag = 1'b0;
                                end
                                mid_pkg::CW_WDOG_CLEAR: begin
                                    st_d.wdogClear = 1'b1;
                                    st_d.flags.timeoutFlag = 1'b1;
                                    st_d.flags.powerdownFlag = 1'b1;
                                end
                                default: ;
                            endcase
                        end
                        mid_pkg::OP_CLEAR: res = 8'h00;
                        mid_pkg::OP_SUB_W: begin
                            sum = addc(fval, ~st_q.acc, 1'b1);
                            updC = 1'b1;
                            updDC = 1'b1;
                        end
                        mid_pkg::OP_DEC: res = fval - 8'h01;
                        mid_pkg::OP_OR_W: res = st_q.acc | fval;
                        mid_pkg::OP_AND_W: res = st_q.acc & fval;
                        mid_pkg::OP_XOR_W: res = st_q.acc ^ fval;
                        mid_pkg::OP_ADD_W: begin
                            sum = addc(fval, st_q.acc, 1'b0);
                            updC = 1'b1;
                            updDC = 1'b1;
                        end
                        mid_pkg::OP_MOVE_F: res = fval;
                        mid_pkg::OP_COMPL: res = ~fval;
                        mid_pkg::OP_INC: res = fval + 8'h01;
                        mid_pkg::OP_DEC_SKIP: begin
                            updZ = 1'b0;
                            res = fval - 8'h01;
                            skipTake = (res == 8'h00);
                        end
                        mid_pkg::OP_ROT_RIGHT: begin
                            updZ = 1'b0;
                            updC = 1'b1;
                            sum = {fval[0], 1'b0, st_q.flags.carry, fval[7:1]};
                        end
                        mid_pkg::OP_ROT_LEFT: begin
                            updZ = 1'b0;
                            updC = 1'b1;
                            sum = {fval[7], 1'b0, fval[6:0], st_q.flags.carry};
                        end
                        mid_pkg::OP_SWAP: begin
                            updZ = 1'b0;
                            res = {fval[3:0], fval[7:4]};
                        end
                        default: begin
                            updZ = 1'b0;
                            res = fval + 8'h01;
                            skipTake = (res == 8'h00);
                        end
                    endcase
                    if (updC) res = sum[7:0];
                end
                mid_pkg::GRP_BIT: begin
                    case (st_q.ir[11:10])
                        2'h0: begin
                            toFile = 1'b1;
                            wrDest = 1'b1;
                            res = fval & ~bitMask;
                        end
                        2'h1: begin
                            toFile = 1'b1;
                            wrDest = 1'b1;
                            res = fval | bitMask;
                        end
                        2'h2: skipTake = (fval & bitMask) == 8'h00;
                        default: skipTake = (fval & bitMask) != 8'h00;
                    endcase
                end
                mid_pkg::GRP_JUMP: begin
                    if (!st_q.ir[11]) begin
                        stkWe = 1'b1;
                        stkWdata = st_q.pc + 13'h0001;
                        st_d.sp = spInc;
                    end
                    st_d.pc = {st_q.pc[12:11], st_q.ir[10:0]};
                    st_d.flush = 1'b1;
                end
                default: begin
                    wrDest = 1'b1;
                    updZ = 1'b1;
                    casez (st_q.ir[11:8])
                        4'b00??: begin
                            updZ = 1'b0;
                            res = st_q.ir[7:0];
                        end
                        4'b01??: begin
                            updZ = 1'b0;
                            res = st_q.ir[7:0];
                            st_d.sp = spDec;
                            st_d.pc = stkMem[spDec];
                            st_d.flush = 1'b1;
                        end
                        mid_pkg::LIT_OR: res = st_q.acc | st_q.ir[7:0];
                        mid_pkg::LIT_AND: res = st_q.acc & st_q.ir[7:0];
                        mid_pkg::LIT_XOR: res = st_q.acc ^ st_q.ir[7:0];
                        4'b110?: begin
                            sum = addc(st_q.ir[7:0], ~st_q.acc, 1'b1);
                            res = sum[7:0];
                            updC = 1'b1;
                            updDC = 1'b1;
                        end
                        4'b111?: begin
                            sum = addc(st_q.ir[7:0], st_q.acc, 1'b0);
                            res = sum[7:0];
                            updC = 1'b1;
                            updDC = 1'b1;
                        end
                        default: begin
                            wrDest = 1'b0;
                            updZ = 1'b0;
                        end
                    endcase
                end
            endcase
            if (wrDest && toFile) memWe = 1'b1;
            if (wrDest && !toFile) st_d.acc = res;
            if (memWe) begin
                case (fileAddr)
                    mid_pkg::FA_STATUS: begin
                        st_d.flags.zero = res[2];
                        st_d.flags.digitCarryFlag = res[1];
                        st_d.flags.carry = res[0];
                    end
                    mid_pkg::FA_PCLOW: begin
                        st_d.pc = {st_q.pc[12:8], res};
                        st_d.flush = 1'b1;
                    end
                    mid_pkg::FA_PORT: st_d.portOut = res;
                    mid_pkg::FA_TIMER0: st_d.prescaleClear = st_q.prescaleToTimer;
                    default: ;
                endcase
            end
            if (updZ) st_d.flags.zero = (res == 8'h00);
            if (updC) st_d.flags.carry = sum[9];
            if (updDC) st_d.flags.digitCarryFlag = sum[8];
            if (skipTake) begin
                st_d.pc = st_q.pc + 13'h0002;
                st_d.flush = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q <= mid_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (memWe) fileMem[fileAddr] <= res;
        if (stkWe) stkMem[st_q.sp] <= stkWdata;
    end

    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
    assign progAddr = st_q.pc;
    assign portOut = st_q.portOut;
    assign wdogClear = st_q.wdogClear;
    assign prescaleClear = st_q.prescaleClear;
    assign standby = st_q.sleeping;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence idleCycle;
        st_q.flush [*4] ##1 !st_q.flush;
    endsequence

    a_decskip_zero: assert property (
        exec && st_q.ir[13:8] == 6'h0b && fval == 8'h01 |=> idleCycle)
        else $error("decrement skip did not idle a cycle");
    a_incskip_zero: assert property (
        exec && st_q.ir[13:8] == 6'h0f && fval == 8'hff
        |=> st_q.flush && st_q.pc == $past(st_q.pc) + 13'h0002)
        else $error("increment skip did not skip");
    a_or_file_acc: assert property (
        exec && st_q.ir[13:7] == 7'h08 && fileAddr != mid_pkg::FA_STATUS
        |=> st_q.acc == ($past(st_q.acc) | $past(fval)) && $stable(st_q.flags.carry))
        else $error("file OR result wrong");
    a_xor_file_zero: assert property (
        exec && st_q.ir[13:8] == 6'h06
        |=> st_q.flags.zero == (($past(st_q.acc) ^ $past(fval)) == 8'h00))
        else $error("file XOR zero flag wrong");
    a_rotate_carry: assert property (
        exec && st_q.ir[13:8] == 6'h0d && fileAddr != mid_pkg::FA_STATUS
        |=> st_q.flags.carry == $past(fval[7]))
        else $error("rotate left carry wrong");
    a_bit_set_write: assert property (
        exec && st_q.ir[13:10] == 4'h5 |-> memWe && (res & bitMask) != 8'h00)
        else $error("bit set not written");
    a_bit_clear_skip: assert property (
        exec && st_q.ir[13:10] == 4'h6 && (fval & bitMask) == 8'h00
        |=> idleCycle)
        else $error("bit test clear did not skip");
    a_or_lit_acc: assert property (
        exec && st_q.ir[13:8] == 6'h38
        |=> st_q.acc == ($past(st_q.acc) | $past(st_q.ir[7:0])) && !st_q.flush)
        else $error("literal OR wrong");
    a_sub_lit_acc: assert property (
        exec && st_q.ir[13:9] == 5'h1e
        |=> st_q.acc == $past(st_q.ir[7:0]) - $past(st_q.acc))
        else $error("literal subtract wrong");
    a_retlit_two: assert property (
        exec && st_q.ir[13:10] == 4'hd |=> st_q.acc == $past(st_q.ir[7:0]) ##0 idleCycle)
        else $error("return with literal wrong");
    a_standby_flags: assert property (
        exec && st_q.ir == mid_pkg::CW_STANDBY
        |=> st_q.sleeping && st_q.flags.timeoutFlag && !st_q.flags.powerdownFlag && !st_q.flush)
        else $error("standby flags wrong");
    a_pin_readback: assert property (
        exec && st_q.ir[13:7] == 7'h11 && fileAddr == mid_pkg::FA_PORT
        |=> st_q.portOut == $past(st_q.portSync))
        else $error("port rewrite not from pins");
    a_prescale_clear: assert property (
        memWe && fileAddr == mid_pkg::FA_TIMER0 && st_q.prescaleToTimer
        |=> prescaleClear ##1 !prescaleClear)
        else $error("prescaler clear missing");
    a_jump_two: assert property (
        exec && st_q.ir[13:11] == 3'h5
        |=> st_q.pc == {$past(st_q.pc[12:11]), $past(st_q.ir[10:0])} ##0 idleCycle)
        else $error("jump not two cycles");
    a_dest_accum: assert property (
        exec && st_q.ir[13:7] == 7'h10 |-> !memWe)
        else $error("destination zero wrote file");
    a_phase_step: assert property (
        st_q.run |=> st_q.phase == $past(st_q.phase) + 2'h1)
        else $error("phase counter did not step");
endmodule // mid_core
`default_nettype wire

/* testbench/mid_prog_mem.sv */
// Program memory model with fetch counters per address
`timescale 1ns/1ps
`default_nettype none
module mid_prog_mem (
    input wire logic clk_sys,
    input wire logic clrHits,
    input wire logic [12:0] progAddr,
    output logic [13:0] progData
);
    logic [13:0] rom [0:63];
    int hits [0:63];
    // One-cycle registered read, garbage outside the model
    always @(posedge clk_sys) begin
        progData <= (progAddr < 13'h0040) ? rom[progAddr[5:0]] : ~progData;
        if (clrHits) begin
            hits <= '{default: 0};
        end else if (progAddr < 13'h0040) begin
            hits[progAddr[5:0]] <= hits[progAddr[5:0]] + 1;
        end
    end
endmodule // mid_prog_mem
`default_nettype wire

/* testbench/mid_core_tb_top.sv */
// Self-checking bench for the instruction decoder core
`timescale 1ns/1ps
`default_nettype none
module mid_core_tb_top;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic wdogClear, prescaleClear, standby, sk;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, rnd, e;
    logic [12:0] progAddr;
    logic [13:0] progData;
    logic [13:0] pg [$];
    logic [7:0] portPins, portOut, a, b, c, d, f, w;
    int n_fail, checks, nWd, nPs;
    mid_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .progAddr(progAddr),
        .progData(progData), .portPins(portPins), .portOut(portOut), .wdogClear(wdogClear),
        .prescaleClear(prescaleClear), .standby(standby));
    mid_prog_mem i_mem (.clk_sys(clk_sys), .clrHits(sys_rst), .progAddr(progAddr),
        .progData(progData));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        nWd <= sys_rst ? 0 : nWd + int'(wdogClear);
        nPs <= sys_rst ? 0 : nPs + int'(prescaleClear);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Skip chain result: {skip, zero, carry, acc}
    function automatic logic [31:0] bexp(input logic [7:0] x, input logic inc);
        logic [7:0] g, r;
        g = {x[7], x[7:1]};
        r = inc ? g + 8'h1 : g - 8'h1;
        return {21'h0, r == 8'h0, (r == 8'h0) ? x == 8'h0 : r == 8'h0, x[0],
            (r == 8'h0) ? {x[6:0], 1'b0} : r};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
        int k;
        k = 0;
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) n_fail++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, '0);
        cmp(q, exp);
    endtask
    // Reset, load the program, run until the final address
    task automatic go(input logic [31:0] ctrl, input logic [12:0] last);
        int k;
        sys_rst <= 1'b1;
        for (k = 0; k < pg.size(); k++) i_mem.rom[k] = pg[k];
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b1, mid_pkg::REG_CTRL, ctrl);
        k = 0;
        while (progAddr !== last && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 400) n_fail++;
        repeat (12) @(posedge clk_sys);
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        portPins = 8'h00;
        n_fail = 0;
        checks = 0;
        rnd = 32'hcc6b4ab7;
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            a = rnd[7:0];
            b = rnd[15:8];
            c = rnd[23:16];
            w = (a | b) ^ c;
            d = (i == 0) ? w : rnd[31:24];
            pg = '{14'h3000 | 14'(a), 14'h3800 | 14'(b), 14'h3a00 | 14'(c), 14'h3c00 | 14'(d), 14'h2004};
            go(32'h1, 13'h4);
            rd(mid_pkg::REG_ACC, {24'h0, d - w});
            rd(mid_pkg::REG_STATUS, {26'h0, 3'h3, d == w, d[3:0] >= w[3:0], d >= w});
            cmp(32'(i_mem.hits[1]), 32'h4);
        end
        bus(1'b1, mid_pkg::REG_ACC, 32'hff);
        rd(mid_pkg::REG_ACC, {24'h0, d - w});
        rd(5'h14, 32'h0);
        rd(mid_pkg::REG_PC, 32'h4);
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            a = (i < 2) ? 8'h00 : rnd[7:0];
            b = (i == 0) ? 8'h02 : (i == 1) ? 8'hff : rnd[15:8];
            e = bexp(b & ~a, i[0]);
            pg = '{14'h3000 | 14'(a), 14'h00a0, 14'h3000 | 14'(b), 14'h0420, 14'h06a0, 14'h0d20,
                14'h0ca0, i[0] ? 14'h0fa0 : 14'h0ba0, 14'h0820, 14'h0000, 14'h200a};
            go(32'h1, 13'ha);
            rd(mid_pkg::REG_ACC, {24'h0, e[7:0]});
            rd(mid_pkg::REG_STATUS, {26'h0, 3'h3, e[9], 1'b0, e[8]});
            cmp(32'(i_mem.hits[9]), e[10] ? 32'h8 : 32'h4);
        end
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            a = rnd[7:0];
            f = i[0] ? a | (8'h1 << rnd[10:8]) : a & ~(8'h1 << rnd[10:8]);
            sk = i[1] ? f[rnd[13:11]] : !f[rnd[13:11]];
            pg = '{14'h3000 | 14'(a), 14'h00a1, {3'h2, i[0], rnd[10:8], 7'h21},
                {3'h3, i[1], rnd[13:11], 7'h21}, 14'h30a5, 14'h0000, 14'h2006};
            go(32'h1, 13'h6);
            rd(mid_pkg::REG_ACC, sk ? {24'h0, a} : 32'ha5);
            rd(mid_pkg::REG_STATUS, 32'h18);
            cmp(32'(i_mem.hits[5]), sk ? 32'h8 : 32'h4);
        end
        rnd = xs(rnd);
        pg = '{14'h2003, 14'h2001, 14'h0000, 14'h3400 | 14'(rnd[7:0])};
        go(32'h1, 13'h1);
        rd(mid_pkg::REG_ACC, {24'h0, rnd[7:0]});
        cmp(32'(i_mem.hits[3]), 32'h8);
        cmp(32'(i_mem.hits[2]), 32'h0);
        pg = '{14'h0064, 14'h0063, 14'h2002};
        go(32'h1, 13'h2);
        rd(mid_pkg::REG_STATUS, 32'h30);
        cmp({31'h0, standby}, 32'h1);
        cmp(32'(nWd), 32'h1);
        bus(1'b1, mid_pkg::REG_WAKE, 32'h1);
        rd(mid_pkg::REG_STATUS, 32'h10);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            a = rnd[7:0];
            portPins <= a ^ (rnd[15:8] | 8'h01);
            pg = '{14'h3000 | 14'(a), 14'h0086, 14'h0886, 14'h0081, 14'h2004};
            go(i[0] ? 32'h3 : 32'h1, 13'h4);
            cmp({24'h0, portOut}, {24'h0, portPins});
            cmp(32'(nPs), {31'h0, i[0]});
        end
        summarize();
    end
endmodule // mid_core_tb_top
`default_nettype wire
